// ### hw/tcm_pkg.sv
// Purpose: shared constants and types for the timer compare-output block
// Assumes: 200 MHz pclk, 16-bit counter, three channels (1A, 1B, 2A)
// Notes: channel index 0 = 1A, 1 = 1B, 2 = 2A
package tcm_pkg;
    // widths
    localparam int CNT_W = 16;
    localparam int NCH = 3;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CFG_W = 11;
    // register map (byte addresses)
    localparam logic [ADDR_W-1:0] FLTR_OFS = 12'h01C;
    localparam logic [ADDR_W-1:0] STAT_OFS = 12'h040;
    localparam logic [CFG_W-1:0] FLTR_RESET = 11'h000;
    // field positions inside the control/filter register
    localparam int MODE_W = 3;
    localparam int CH1A_MODE_LSB = 0;
    localparam int CH1A_PHASE_BIT = 3;
    localparam int CH1B_MODE_LSB = 4;
    localparam int CH1B_PHASE_BIT = 7;
    localparam int CH2A_MODE_LSB = 8;
    localparam int MODE_LSB [NCH] = '{CH1A_MODE_LSB, CH1B_MODE_LSB, CH2A_MODE_LSB};
    // status register layout
    localparam int STAT_OUT_LSB = 0;
    localparam int STAT_IN_LSB = 3;
    // compare output modes
    typedef enum logic [2:0] {
        MODE_FORCE_LO = 3'h0,
        MODE_FORCE_HI = 3'h1,
        MODE_CLR_MATCH = 3'h2,
        MODE_SET_MATCH = 3'h3,
        MODE_TOGGLE = 3'h4,
        MODE_PULSE = 3'h5,
        MODE_PWM1 = 3'h6,
        MODE_PWM2 = 3'h7
    } tcm_mode_t;
    // input filter: top bit enables, low bits pick the sample rate
    localparam int FLT_EN_BIT = 2;
    localparam int FLT_SEL_W = 2;
    localparam int FLT_NRATE = 4;
    localparam int DIV_W = 6;
    localparam logic [DIV_W-1:0] DIV4_MASK = 6'h03;
    localparam logic [DIV_W-1:0] DIV16_MASK = 6'h0F;
    localparam logic [DIV_W-1:0] DIV64_MASK = 6'h3F;
endpackage : tcm_pkg

// ### hw/tcm_flt_if.sv
// Purpose: carrier between the top and one input filter
// Assumes: one instance per channel
// Notes: tick holds the four sample-rate enables
`timescale 1ns/1ps
interface tcm_flt_if;
    logic [2:0] code;
    logic [tcm_pkg::FLT_NRATE-1:0] tick;
    logic raw;
    logic filt;
    modport ctl (output code, output tick, output raw, input filt);
    modport flt (input code, input tick, input raw, output filt);
endinterface : tcm_flt_if

// ### hw/tcm_in_filter.sv
// Purpose: three-equal-sample input filter for one capture input
// Assumes: raw is already synchronised to pclk
// Notes: disabled codes pass the input through one flop
`timescale 1ns/1ps
module tcm_in_filter (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // filter connection
    tcm_flt_if.flt fi
);
    import tcm_pkg::*;

    logic [1:0] hist_ff;
    logic filt_ff;
    logic smp;

    // sample enable chosen by the rate code
    assign smp = fi.tick[fi.code[FLT_SEL_W-1:0]];
    assign fi.filt = filt_ff;

    // sample history, shifted only at the chosen rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_ff <= 2'h0;
        end else if (smp) begin
            hist_ff <= {hist_ff[0], fi.raw};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_ff <= 1'b0;
        end else if (!fi.code[FLT_EN_BIT]) begin
            filt_ff <= fi.raw; // filtering off
        end else if (smp && hist_ff[0] == fi.raw && hist_ff[1] == fi.raw) begin
            filt_ff <= fi.raw;
        end
    end
endmodule : tcm_in_filter

// ### hw/tcm_top.sv
// Purpose: compare-output modes, phase control and input filters of three timer channels
// Assumes: counter, compare registers and direction come from the timer core on pclk
// Notes: register at 0x1C holds bits 10:0; a status word shows channel levels
// Function
// - modes 000/001 force output low/high
// - modes 010/011 clear/set on match
// - mode 100 toggles on each match
// - mode 101 gives one-count-period high pulse
// - PWM1 single point by count direction
// - PWM1 two point uses A and B
// - PWM2 is complement of PWM1
// - bit 7 inverts channel 1B output
// - slave mode: bit 7 inverts 1B input
// - bit 3 inverts 1A output or input; the input is inverted only in slave mode
// - bits 2:0 are 1A mode or filter
// - bits 10:8 are 2A mode or filter
// - filter: three equal samples at the selected rate (pclk, /4, /16 or /64)
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module tcm_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tcm_pkg::ADDR_W-1:0] paddr,
    input wire logic [tcm_pkg::DATA_W-1:0] pwdata,
    output logic [tcm_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer core
    input wire logic [tcm_pkg::CNT_W-1:0] cnt,
    input wire logic cnt_tick,
    input wire logic count_up,
    input wire logic center_aligned,
    input wire logic slave_mode,
    input wire logic ch2a_phase_sel,
    input wire logic [tcm_pkg::NCH-1:0] capture_sel,
    input wire logic [tcm_pkg::NCH-1:0] two_point,
    input wire logic [tcm_pkg::NCH-1:0][tcm_pkg::CNT_W-1:0] ccr_a,
    input wire logic [tcm_pkg::NCH-1:0][tcm_pkg::CNT_W-1:0] ccr_b,
    // channel pins
    input wire logic [tcm_pkg::NCH-1:0] ch_pin_in,
    output logic [tcm_pkg::NCH-1:0] ch_out,
    output logic [tcm_pkg::NCH-1:0] ch_in_filt
);
    import tcm_pkg::*;

    logic [CFG_W-1:0] cfg_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [DATA_W-1:0] prdata_ff;
    logic [DIV_W-1:0] div_ff;
    logic [FLT_NRATE-1:0] tick;
    logic [NCH-1:0] phase;
    logic [NCH-1:0] ref_ff;
    logic [NCH-1:0] eq_ff;
    logic [NCH-1:0] out_ff;
    logic [NCH-1:0] in_filt_ff;
    logic [NCH-1:0] sync1_ff;
    logic [NCH-1:0] sync2_ff;
    logic [NCH-1:0] sync3_ff;
    logic [NCH-1:0] pin_ff;
    logic [NCH-1:0] in_pol;
    logic apb_done;
    logic hit_fltr;
    logic hit_stat;
    logic [DATA_W-1:0] nxt_prdata;

    // apb decode; the transfer completes in the cycle pready is high
    assign hit_fltr = (paddr == FLTR_OFS);
    assign hit_stat = (paddr == STAT_OFS);
    assign apb_done = psel && penable && pready_ff;

    // one wait state keeps pready and read data straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
        end
    end

    // read mux: reserved bits above the fields read as zero
    always_comb begin
        nxt_prdata = '0;
        if (hit_fltr) begin
            nxt_prdata = DATA_W'(cfg_ff);
        end else if (hit_stat) begin
            nxt_prdata[STAT_OUT_LSB +: NCH] = out_ff;
            nxt_prdata[STAT_IN_LSB +: NCH] = in_filt_ff;
        end
    end

    // read data and error captured alongside pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end else if (psel && penable && !pready_ff) begin
            prdata_ff <= pwrite ? '0 : nxt_prdata;
            pslverr_ff <= !(hit_fltr || (hit_stat && !pwrite)); // status is read-only
        end else begin
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= FLTR_RESET;
        end else if (apb_done && pwrite && hit_fltr) begin
            cfg_ff <= pwdata[CFG_W-1:0];
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + DIV_W'(1);
        end
    end

    // rate enables: pclk, /4, /16, /64
    assign tick[0] = 1'b1;
    assign tick[1] = ((div_ff & DIV4_MASK) == DIV4_MASK);
    assign tick[2] = ((div_ff & DIV16_MASK) == DIV16_MASK);
    assign tick[3] = (div_ff == DIV64_MASK);

    // per-channel phase bits; 2A phase lives outside this field range
    assign phase[0] = cfg_ff[CH1A_PHASE_BIT];
    assign phase[1] = cfg_ff[CH1B_PHASE_BIT];
    assign phase[2] = ch2a_phase_sel;

    // input polarity only in slave mode
    assign in_pol[0] = slave_mode && cfg_ff[CH1A_PHASE_BIT];
    assign in_pol[1] = slave_mode && cfg_ff[CH1B_PHASE_BIT];
    assign in_pol[2] = 1'b0;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            tcm_mode_t mode;
            logic eq;
            logic match;
            logic pwm_single;
            logic pwm_two;
            logic pwm1;
            tcm_flt_if fif ();

            assign mode = tcm_mode_t'(cfg_ff[MODE_LSB[g] +: MODE_W]);
            assign eq = (cnt == ccr_a[g]);
            // match fires once when the counter reaches the compare value
            assign match = eq && !eq_ff[g] && !capture_sel[g];

            assign pwm_single = count_up ? (cnt < ccr_a[g]) : (cnt <= ccr_a[g]);
            // two point, edge or center aligned
            assign pwm_two = !center_aligned ? !((ccr_a[g] < cnt) && (cnt <= ccr_b[g])) :
                             count_up ? (cnt < ccr_a[g]) : !(cnt > ccr_b[g]);
            assign pwm1 = two_point[g] ? pwm_two : pwm_single;

            // equality history for match edge
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    eq_ff[g] <= 1'b0;
                end else begin
                    eq_ff[g] <= eq;
                end
            end

            // reference level per compare mode
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ref_ff[g] <= 1'b0;
                end else begin
                    case (mode)
                        MODE_FORCE_LO: ref_ff[g] <= 1'b0;
                        MODE_FORCE_HI: ref_ff[g] <= 1'b1;
                        MODE_CLR_MATCH: begin
                            if (match) begin
                                ref_ff[g] <= 1'b0;
                            end
                        end
                        MODE_SET_MATCH: begin
                            if (match) begin
                                ref_ff[g] <= 1'b1;
                            end
                        end
                        MODE_TOGGLE: begin
                            if (match) begin
                                ref_ff[g] <= !ref_ff[g];
                            end
                        end
                        MODE_PULSE: begin
                            if (match) begin
                                ref_ff[g] <= 1'b1;
                            end else if (cnt_tick) begin
                                ref_ff[g] <= 1'b0;
                            end
                        end
                        MODE_PWM1: ref_ff[g] <= pwm1;
                        MODE_PWM2: ref_ff[g] <= !pwm1;
                        default: ref_ff[g] <= 1'b0;
                    endcase
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    out_ff[g] <= 1'b0;
                end else begin
                    out_ff[g] <= capture_sel[g] ? 1'b0 : (ref_ff[g] ^ phase[g]);
                end
            end

            // three-flop pin sync; only the second flop reads the first
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_ff[g] <= 1'b0;
                    sync2_ff[g] <= 1'b0;
                    sync3_ff[g] <= 1'b0;
                end else begin
                    sync1_ff[g] <= ch_pin_in[g];
                    sync2_ff[g] <= sync1_ff[g];
                    sync3_ff[g] <= sync2_ff[g];
                end
            end

            // a change counts once second and third stages agree
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_ff[g] <= 1'b0;
                end else if (sync2_ff[g] == sync3_ff[g]) begin
                    pin_ff[g] <= sync3_ff[g];
                end
            end

            // field acts as filter when capturing
            assign fif.code = capture_sel[g] ? cfg_ff[MODE_LSB[g] +: MODE_W] : 3'h0;
            assign fif.tick = tick;
            assign fif.raw = pin_ff[g] ^ in_pol[g];

            tcm_in_filter u_flt (
                .pclk(pclk),
                .presetn(presetn),
                .fi(fif.flt)
            );

            // filtered input registered at the top boundary
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    in_filt_ff[g] <= 1'b0;
                end else begin
                    in_filt_ff[g] <= fif.filt;
                end
            end
        end
    endgenerate

    assign ch_out = out_ff;
    assign ch_in_filt = in_filt_ff;
endmodule : tcm_top

// ### tb/tcm_top_checker.sv
// Purpose: port-level checks of the timer compare block
// Assumes: a shadow of the config field follows apb writes
// Notes: compare outputs land two edges after their cause
`timescale 1ns/1ps
module tcm_top_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tcm_pkg::ADDR_W-1:0] paddr,
    input wire logic [tcm_pkg::DATA_W-1:0] pwdata,
    input wire logic [tcm_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // timer core and outputs
    input wire logic [tcm_pkg::CNT_W-1:0] cnt,
    input wire logic count_up,
    input wire logic [tcm_pkg::NCH-1:0] capture_sel,
    input wire logic [tcm_pkg::NCH-1:0] two_point,
    input wire logic [tcm_pkg::NCH-1:0][tcm_pkg::CNT_W-1:0] ccr_a,
    input wire logic [tcm_pkg::NCH-1:0] ch_out
);
    import tcm_pkg::*;
    logic [CFG_W-1:0] cfg_ff;
    logic [1:0] age_ff;
    logic cfg_wr;
    // shadow config; age saturates so checks wait for the pipeline
    assign cfg_wr = pready && pwrite && paddr == FLTR_OFS;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= FLTR_RESET;
        end else if (cfg_wr) begin
            cfg_ff <= pwdata[CFG_W-1:0];
        end
    end
    // edges since the config last moved
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_ff <= 2'h0;
        end else if (cfg_wr && pwdata[CFG_W-1:0] != cfg_ff) begin
            age_ff <= 2'h0;
        end else if (age_ff != 2'h3) begin
            age_ff <= age_ff + 2'h1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_wait_state: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_rdata_idle: assert property (!pready |-> prdata == '0)
        else $error("prdata not zero");
    a_unmapped_err: assert property (pready && paddr != FLTR_OFS && paddr != STAT_OFS |-> pslverr)
        else $error("unmapped without slverr");
    a_status_ro: assert property (pready && pwrite && paddr == STAT_OFS |-> pslverr)
        else $error("status write accepted");
    a_mapped_ok: assert property (pready && !pwrite && (paddr == FLTR_OFS || paddr == STAT_OFS) |-> !pslverr)
        else $error("mapped read refused");
    a_cfg_readback:
    assert property (pready && !pwrite && paddr == FLTR_OFS |-> prdata == DATA_W'(cfg_ff))
        else $error("config readback wrong");
    a_force_level:
    assert property (age_ff == 2'h3 && cfg_ff[6:5] == 2'h0 && !capture_sel[1] && !$past(capture_sel[1])
        && !$past(capture_sel[1], 2) |-> ch_out[1] == (cfg_ff[4] ^ cfg_ff[7]))
        else $error("forced level wrong");
    a_pwm_single:
    assert property (age_ff == 2'h3 && cfg_ff[2:0] == 3'h6 && !capture_sel[0] && !$past(capture_sel[0])
        && !$past(capture_sel[0], 2) && !$past(two_point[0], 2) && $past(count_up, 2)
        |-> ch_out[0] == (($past(cnt, 2) < $past(ccr_a[0], 2)) ^ cfg_ff[3]))
        else $error("pwm level wrong");
endmodule : tcm_top_checker

bind tcm_top tcm_top_checker tcm_top_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cnt, .count_up, .capture_sel, .two_point, .ccr_a, .ch_out);

// ### tb/tcm_top_tb.sv
// Purpose: self-checking bench for the timer compare block
// Assumes: apb answers after one wait state
// Notes: read results are queued by the driver, checked by a monitor
`timescale 1ns/1ps
module tcm_top_tb;
    import tcm_pkg::*;
    typedef struct {logic rd; logic err; logic [31:0] d; logic [31:0] m;} tcm_note_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cnt_tick, count_up, center_aligned;
    logic slave_mode, ch2a_phase_sel;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, v, r;
    logic [CNT_W-1:0] cnt, a, b, c;
    logic [NCH-1:0] capture_sel, two_point, ch_pin_in, ch_out, ch_in_filt;
    logic [NCH-1:0][CNT_W-1:0] ccr_a, ccr_b;
    tcm_note_t q[$];
    tcm_note_t n;
    int fail_count, checks, cyc;
    tcm_top tcm_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cnt, .cnt_tick, .count_up, .center_aligned, .slave_mode, .ch2a_phase_sel, .capture_sel,
        .two_point, .ccr_a, .ccr_b, .ch_pin_in, .ch_out, .ch_in_filt);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    // one apb transfer; the note is taken by the monitor at pready
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d, input tcm_note_t e);
        q.push_back(e);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic cfg(input logic [10:0] m);
        apb(1'h1, FLTR_OFS, {21'($urandom), m}, '{1'h0, 1'h0, 32'h0, 32'h0});
    endtask : cfg
    // status read after the output pipeline has settled
    task automatic st(input logic [5:0] e, input logic [5:0] m);
        repeat (4) @(posedge pclk);
        apb(1'h0, STAT_OFS, 32'h0, '{1'h1, 1'h0, 32'(e), 32'(m)});
    endtask : st
    task automatic step(input logic [15:0] x);
        @(posedge pclk);
        cnt <= x;
        cnt_tick <= 1'h1;
        @(posedge pclk);
        cnt_tick <= 1'h0;
    endtask : step
    // match modes on the first channel: level after a match, then after a non-matching step
    task automatic mt(input logic [2:0] pre, input logic [2:0] m, input logic e1, input logic e2);
        cfg({8'h00, pre});
        cfg({8'h00, m});
        step(a + 16'h1);
        step(a);
        st({5'h00, e1}, 6'h01);
        step(a + 16'h1);
        st({5'h00, e2}, 6'h01);
    endtask : mt
    function automatic logic pwm1(input logic [15:0] x, input logic [2:0] s);
        if (!s[2]) return s[0] ? x < a : x <= a;
        if (!s[1]) return !(a < x && x <= b);
        return s[0] ? x < a : x <= b;
    endfunction : pwm1
    initial begin
        pclk = 1'h0;
        forever #2.5 pclk = ~pclk;
    end
    // monitor: oldest note against each answer
    always @(posedge pclk) begin
        if (pready === 1'h1 && q.size() > 0) begin
            n = q.pop_front();
            check(32'(pslverr), 32'(n.err));
            if (n.rd) check(prdata & n.m, n.d);
        end
    end
    // hang guard, well above the expected run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            $display("ERROR %0t: timeout", $time);
            results();
        end
    end
    initial begin
        void'($urandom(32'h376B));
        {presetn, psel, penable, pwrite, cnt_tick, count_up, center_aligned, slave_mode, ch2a_phase_sel} = '0;
        {paddr, pwdata, cnt, capture_sel, two_point, ch_pin_in, ccr_a, ccr_b} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, FLTR_OFS, 32'h0, '{1'h1, 1'h0, 32'(FLTR_RESET), 32'hFFFFFFFF});
        v = $urandom;
        apb(1'h1, FLTR_OFS, v, '{1'h0, 1'h0, 32'h0, 32'h0});
        apb(1'h0, FLTR_OFS, 32'h0, '{1'h1, 1'h0, v & 32'h7FF, 32'hFFFFFFFF});
        apb(1'h0, 12'h020, 32'h0, '{1'h1, 1'h1, 32'h0, 32'hFFFFFFFF});
        apb(1'h1, STAT_OFS, v, '{1'h0, 1'h1, 32'h0, 32'h0});
        for (int i = 0; i < 8; i++) begin
            ch2a_phase_sel <= i[2];
            cfg({2'h0, i[0], i[1], 2'h0, i[0], i[1], 2'h0, i[0]});
            st({3'h0, i[0] ^ i[2], i[0] ^ i[1], i[0] ^ i[1]}, 6'h07);
        end
        a = 16'($urandom);
        ccr_a[0] <= a;
        mt(3'h1, 3'h2, 1'h0, 1'h0);
        mt(3'h0, 3'h3, 1'h1, 1'h1);
        mt(3'h0, 3'h4, 1'h1, 1'h1);
        mt(3'h4, 3'h4, 1'h0, 1'h0);
        mt(3'h0, 3'h5, 1'h1, 1'h0);
        for (int i = 0; i < 24; i++) begin
            r = $urandom;
            a = 16'(r[7:5]);
            b = 16'(r[10:8]);
            c = 16'(r[13:11]);
            ccr_a[0] <= a;
            ccr_b[0] <= b;
            count_up <= r[0];
            center_aligned <= r[1];
            two_point[0] <= r[2];
            cfg({7'h00, r[3], 2'h3, r[4]});
            step(c);
            st({5'h00, pwm1(c, r[2:0]) ^ r[4] ^ r[3]}, 6'h01);
        end
        capture_sel <= 3'h7;
        slave_mode <= 1'h1;
        for (int k = 0; k < 8; k++) begin
            ch_pin_in <= 3'h0;
            cfg({k[2:0], 1'h1, k[2:0], 1'h1, k[2:0]});
            if (k > 3) begin
                ch_pin_in <= 3'h7;
                repeat (2) @(posedge pclk);
                ch_pin_in <= 3'h0;
            end
            repeat (300) @(posedge pclk);
            st(6'h18, 6'h3F);
            ch_pin_in <= 3'h7;
            repeat (300) @(posedge pclk);
            st(6'h20, 6'h3F);
        end
        repeat (4) @(posedge pclk);
        results();
    end
endmodule : tcm_top_tb
